// >>> rtl/sapw_defines.svh
/*
 * Constants of the scaled analog PWM block: register offsets, field
 * positions, reset values, value limits and time base figures.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef SAPW_DEFINES_SVH
`define SAPW_DEFINES_SVH

// Register byte offsets
`define SAPW_OFS_CTRL    8'h00
`define SAPW_OFS_GAIN    8'h04
`define SAPW_OFS_OFFSET  8'h08
`define SAPW_OFS_MIN     8'h0C
`define SAPW_OFS_MAX     8'h10
`define SAPW_OFS_PERIOD  8'h14
`define SAPW_OFS_DEC     8'h18
`define SAPW_OFS_STATUS  8'h1C
`define SAPW_OFS_SCALED  8'h20

// Field positions
`define SAPW_CTRL_PSRC_BIT  0
`define SAPW_STAT_OUT_BIT   0
`define SAPW_STAT_RUN_BIT   1

// Reset values
`define SAPW_CTRL_RST    1'h0
`define SAPW_GAIN_RST    16'h0064
`define SAPW_OFFSET_RST  16'h0000
`define SAPW_MIN_RST     16'h0000
`define SAPW_MAX_RST     16'h03E8
`define SAPW_PERIOD_RST  16'h03E8
`define SAPW_DEC_RST     2'h0

// Setting limits: gain in hundredths, offset in counts
`define SAPW_GAIN_LIM    32'sh0000_03E8
`define SAPW_OFFSET_LIM  32'sh0000_2710
`define SAPW_GAIN_DIV    32'sh0000_0064

// Time base: one period step in ns, clock period in ns
`define SAPW_TICK_NS     1000000
`define SAPW_CLK_NS      25

`endif

// >>> rtl/sapw_pkg.sv
/*
 * Types of the scaled analog PWM block.
 * Assumes sapw_defines.svh for numeric constants.
 */
package sapw_pkg;

   // Scaling and range settings carried together
   typedef struct packed {
      logic signed [15:0] gain;
      logic signed [15:0] offset;
      logic signed [15:0] min;
      logic signed [15:0] max;
   } sapw_scale_t;

   // Modulator states
   typedef enum logic {
      SAPW_ST_IDLE,
      SAPW_ST_RUN
   } sapw_state_t;

endpackage

// >>> rtl/sapw_duty.sv
/*
 * Scaling and duty decision of the PWM block: forms the scaled value
 * and decides the output level for a given step within a period.
 * Assumes settings and sample are stable inputs on the same clock.
 */
`timescale 1ns/100ps
`include "sapw_defines.svh"

module sapw_duty (
   input wire sapw_pkg::sapw_scale_t cfg,
   input wire logic signed [15:0] sample,
   input wire logic [15:0] count,
   input wire logic [15:0] period,
   output logic signed [31:0] scaled,
   output logic level
);

   logic signed [31:0] prod;
   logic signed [32:0] num;
   logic signed [32:0] span;
   logic [32:0] lhs;
   logic [32:0] rhs;

   // Gain in hundredths, then offset
   always_comb begin
      prod = 32'(cfg.gain) * 32'(sample);
      scaled = prod / `SAPW_GAIN_DIV + 32'(cfg.offset);
   end

   // Fraction of the range compared by cross products, no divider
   always_comb begin
      num = 33'(scaled) - 33'(cfg.min);
      span = 33'(cfg.max) - 33'(cfg.min);
      lhs = 33'(count) * 33'(span[16:0]);
      rhs = 33'(period) * 33'(num[16:0]);
      if (span <= 33'sh0_0000_0000 || num <= 33'sh0_0000_0000) begin
         level = 1'b0;
      end else if (num >= span) begin
         level = (period != 16'h0000);
      end else begin
         level = (lhs < rhs);
      end
   end

endmodule // sapw_duty

// >>> rtl/sapw_top.sv
/*
 * Scaled analog PWM generator: register port, input synchronisers,
 * period time base and output stage around the duty calculation.
 * Assumes one 40 MHz clock, a synchronous active-low reset, and that
 * the enable and the analog sample come from outside this clock.
 */
`timescale 1ns/100ps
`include "sapw_defines.svh"

// Summary of operation
// - Modulation starts only on a low-to-high change of the enable.
// - The working value is the sample times the gain plus the offset.
// - Gain is held within plus or minus 10.00, offset within 10000.
// - Each period the output is high for the range fraction, else low.
// - The fraction uses the scaled value against the set min and max.
// - The high/low pattern repeats each period while enable stays high.
// - The decimals setting is stored for display and never used here.
// - The period may come from another block's live output value.
module sapw_top #(
   parameter int TICK_CYCLES = `SAPW_TICK_NS / `SAPW_CLK_NS
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic enable_in,
   input wire logic signed [15:0] analog_sample_in,
   input wire logic [15:0] period_ext_in,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic pwm_out,
   output logic running
);

   // Elaboration check: the tick counter is 16 bits wide
   if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_tick_check
      $error("TICK_CYCLES out of range");
   end

   // Saturate a signed write value to plus or minus a limit
   function automatic logic signed [15:0] sat16(
      input logic [31:0] val,
      input logic signed [31:0] lim
   );
      logic signed [31:0] s;
      s = signed'(val);
      if (s > lim) begin
         sat16 = 16'(lim);
      end else if (s < -lim) begin
         sat16 = 16'(-lim);
      end else begin
         sat16 = s[15:0];
      end
   endfunction

   // Run state decode, shared by status read and output
   function automatic logic is_run(input sapw_pkg::sapw_state_t st);
      is_run = (st == sapw_pkg::SAPW_ST_RUN);
   endfunction

   // Synchroniser stages
   logic en_s1_r;
   logic en_s2_r;
   logic en_prev_r;
   logic signed [15:0] smp_s1_r;
   logic signed [15:0] smp_s2_r;

   // Sample word kept once it has settled
   logic signed [15:0] smp_prev_r;
   logic signed [15:0] smp_hold_r;
   logic signed [15:0] smp_hold_nxt;

   // Settings
   logic psrc_r;
   logic psrc_nxt;
   sapw_pkg::sapw_scale_t scale_r;
   sapw_pkg::sapw_scale_t scale_nxt;
   logic [15:0] period_r;
   logic [15:0] period_nxt;
   logic [1:0] dec_r;
   logic [1:0] dec_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   // Time base and output
   sapw_pkg::sapw_state_t state_r;
   sapw_pkg::sapw_state_t state_nxt;
   logic [15:0] tick_r;
   logic [15:0] tick_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [15:0] cur_period_r;
   logic [15:0] cur_period_nxt;
   logic out_r;
   logic out_nxt;

   logic [15:0] period_sel;
   logic enable_rise;
   logic tick_end;
   logic signed [31:0] scaled;
   logic level;

   localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

   // Two-stage synchronisers; edge detect reads the second stage only
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         en_s1_r <= 1'b0;
         en_s2_r <= 1'b0;
         en_prev_r <= 1'b0;
         smp_s1_r <= 16'sh0000;
         smp_s2_r <= 16'sh0000;
         smp_prev_r <= 16'sh0000;
         smp_hold_r <= 16'sh0000;
      end else if (ce) begin
         en_s1_r <= enable_in;
         en_s2_r <= en_s1_r;
         en_prev_r <= en_s2_r;
         smp_s1_r <= analog_sample_in;
         smp_s2_r <= smp_s1_r;
         smp_prev_r <= smp_s2_r;
         smp_hold_r <= smp_hold_nxt;
      end
   end

   assign enable_rise = en_s2_r && !en_prev_r;

   // Sample taken only when two synchronised copies agree,
   // so a word caught mid-change never reaches the scaling
   assign smp_hold_nxt = (smp_s2_r == smp_prev_r) ? smp_s2_r : smp_hold_r;

   // Period source: own setting or another block's live value
   assign period_sel = psrc_r ? period_ext_in : period_r;

   // Register writes and read data
   always_comb begin
      psrc_nxt = psrc_r;
      scale_nxt = scale_r;
      period_nxt = period_r;
      dec_nxt = dec_r;
      rdata_nxt = 32'h0000_0000;
      if (reg_wr) begin
         case (reg_addr)
            `SAPW_OFS_CTRL: begin
               psrc_nxt = reg_wdata[`SAPW_CTRL_PSRC_BIT];
            end
            `SAPW_OFS_GAIN: begin
               scale_nxt.gain = sat16(reg_wdata, `SAPW_GAIN_LIM);
            end
            `SAPW_OFS_OFFSET: begin
               scale_nxt.offset =
                  sat16(reg_wdata, `SAPW_OFFSET_LIM);
            end
            `SAPW_OFS_MIN: begin
               scale_nxt.min = reg_wdata[15:0];
            end
            `SAPW_OFS_MAX: begin
               scale_nxt.max = reg_wdata[15:0];
            end
            `SAPW_OFS_PERIOD: begin
               period_nxt = reg_wdata[15:0];
            end
            `SAPW_OFS_DEC: begin
               dec_nxt = reg_wdata[1:0];
            end
            default: begin
               psrc_nxt = psrc_r;
            end
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `SAPW_OFS_CTRL: begin
               rdata_nxt[`SAPW_CTRL_PSRC_BIT] = psrc_r;
            end
            `SAPW_OFS_GAIN: begin
               rdata_nxt = 32'(scale_r.gain);
            end
            `SAPW_OFS_OFFSET: begin
               rdata_nxt = 32'(scale_r.offset);
            end
            `SAPW_OFS_MIN: begin
               rdata_nxt = 32'(scale_r.min);
            end
            `SAPW_OFS_MAX: begin
               rdata_nxt = 32'(scale_r.max);
            end
            `SAPW_OFS_PERIOD: begin
               rdata_nxt = {16'h0000, period_sel};
            end
            `SAPW_OFS_DEC: begin
               rdata_nxt = {30'h0000_0000, dec_r};
            end
            `SAPW_OFS_STATUS: begin
               rdata_nxt[`SAPW_STAT_OUT_BIT] = out_r;
               rdata_nxt[`SAPW_STAT_RUN_BIT] = is_run(state_r);
            end
            `SAPW_OFS_SCALED: begin
               rdata_nxt = scaled;
            end
            default: begin
               rdata_nxt = 32'h0000_0000;
            end
         endcase
      end
   end

   // Register state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         psrc_r <= `SAPW_CTRL_RST;
         scale_r.gain <= `SAPW_GAIN_RST;
         scale_r.offset <= `SAPW_OFFSET_RST;
         scale_r.min <= `SAPW_MIN_RST;
         scale_r.max <= `SAPW_MAX_RST;
         period_r <= `SAPW_PERIOD_RST;
         dec_r <= `SAPW_DEC_RST;
         rdata_r <= 32'h0000_0000;
      end else if (ce) begin
         psrc_r <= psrc_nxt;
         scale_r <= scale_nxt;
         period_r <= period_nxt;
         dec_r <= dec_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Scaling and duty decision for the current step
   sapw_duty u_duty (
      .cfg(scale_r),
      .sample(smp_hold_r),
      .count(cnt_r),
      .period(cur_period_r),
      .scaled(scaled),
      .level(level)
   );

   assign tick_end = (tick_r == TICK_LAST);

   // Time base: ticks make steps, steps make periods
   always_comb begin
      state_nxt = state_r;
      tick_nxt = tick_r;
      cnt_nxt = cnt_r;
      cur_period_nxt = cur_period_r;
      out_nxt = 1'b0;
      case (state_r)
         sapw_pkg::SAPW_ST_IDLE: begin
            if (enable_rise) begin
               state_nxt = sapw_pkg::SAPW_ST_RUN;
               tick_nxt = 16'h0000;
               cnt_nxt = 16'h0000;
               cur_period_nxt = period_sel;
            end
         end
         sapw_pkg::SAPW_ST_RUN: begin
            if (!en_s2_r) begin
               state_nxt = sapw_pkg::SAPW_ST_IDLE;
            end else begin
               out_nxt = level;
               if (tick_end) begin
                  tick_nxt = 16'h0000;
                  if (cnt_r + 16'h0001 >= cur_period_r) begin
                     cnt_nxt = 16'h0000;
                     cur_period_nxt = period_sel;
                  end else begin
                     cnt_nxt = cnt_r + 16'h0001;
                  end
               end else begin
                  tick_nxt = tick_r + 16'h0001;
               end
            end
         end
         default: begin
            state_nxt = sapw_pkg::SAPW_ST_IDLE;
         end
      endcase
   end

   // Time base state
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_r <= sapw_pkg::SAPW_ST_IDLE;
         tick_r <= 16'h0000;
         cnt_r <= 16'h0000;
         cur_period_r <= 16'h0000;
         out_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         tick_r <= tick_nxt;
         cnt_r <= cnt_nxt;
         cur_period_r <= cur_period_nxt;
         out_r <= out_nxt;
      end
   end

   assign pwm_out = out_r;   // Low whenever not running
   assign running = is_run(state_r);
   assign reg_rdata = rdata_r;

endmodule // sapw_top

// >>> testbench/sapw_monitor.sv
/* Port checker of the scaled PWM block.
   Assumes a bind to sapw_top with ce high whenever it runs. */
`timescale 1ns/100ps
`include "sapw_defines.svh"
module sapw_monitor #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic enable_in,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic pwm_out,
   input wire logic running
);
   int ph_r;
   int ph_nxt;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Cycle within a step, counted from start
   always_comb begin
      ph_nxt = (ph_r == TICK_CYCLES - 1) ? 0 : ph_r + 1;
      if (!running) begin
         ph_nxt = 0;
      end
   end
   always_ff @(posedge clk) begin
      ph_r <= reset_n ? ph_nxt : 0;
   end
   sequence s_en_low3;
      !enable_in [*3];
   endsequence
   sequence s_run_en4;
      (running && enable_in) [*4];
   endsequence
   property p_rd_idle;
      !$past(reg_rd) |-> reg_rdata == 32'h0;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside read answer");
   property p_status;
      reg_rd && reg_addr == `SAPW_OFS_STATUS |=>
         reg_rdata == {30'h0, $past(running), $past(pwm_out)};
   endproperty
   a_status: assert property (p_status)
      else $error("status read wrong");
   property p_unmap;
      reg_rd && reg_addr > `SAPW_OFS_SCALED |=> reg_rdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not zero");
   property p_rise;
      $rose(running) |-> $past(enable_in, 2);
   endproperty
   a_rise: assert property (p_rise)
      else $error("start without enable");
   property p_drop;
      s_en_low3 |=> !running;
   endproperty
   a_drop: assert property (p_drop)
      else $error("running after enable low");
   property p_pwm_run;
      pwm_out |-> $past(running);
   endproperty
   a_pwm_run: assert property (p_pwm_run)
      else $error("output high while idle");
   property p_hold;
      s_run_en4 |=> running;
   endproperty
   a_hold: assert property (p_hold)
      else $error("run stopped with enable high");
   property p_step;
      $changed(pwm_out) && running && $past(running) |-> ph_r == 1;
   endproperty
   a_step: assert property (p_step)
      else $error("output changed off a step");
endmodule // sapw_monitor

// >>> testbench/sapw_source.sv
/* Far-side model: enable, analog sample and period feed.
   Assumes the bench calls drive for every change. */
`timescale 1ns/100ps
module sapw_source (
   input wire logic clk,
   output logic enable_in,
   output logic signed [15:0] analog_sample_in,
   output logic [15:0] period_ext_in
);
   // Quiet analog side at time zero
   initial begin
      enable_in = 1'h0;
      analog_sample_in = 16'h0000;
      period_ext_in = 16'h03E8;
   end
   // Pins change just after a rising edge
   task automatic drive(input logic en, input logic signed [15:0] s,
      input logic [15:0] p);
      @(posedge clk);
      enable_in <= en;
      analog_sample_in <= s;
      period_ext_in <= p;
   endtask
endmodule // sapw_source

// >>> testbench/testbench.sv
/* Self-checking bench of the scaled PWM block.
   Assumes sapw_source on the analog side; ce low only while idle. */
`timescale 1ns/100ps
`include "sapw_defines.svh"
module testbench;
   localparam int TK = 4;
   logic clk = 1'h0;
   logic reset_n = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic ce = 1'h1;
   logic [31:0] reg_rdata;
   logic enable_in, pwm_out, running;
   logic signed [15:0] analog_sample_in;
   logic [15:0] period_ext_in;
   int mismatches = 0;
   int comparisons = 0;
   // Sample, gain, offset, min, max, period
   int rows [8][6] = '{'{500, 100, 0, 0, 1000, 4},
      '{300, 100, 0, 0, 1000, 10}, '{100, 250, 50, 0, 1000, 10},
      '{-200, -150, -100, 0, 1000, 5}, '{900, 200, 0, 0, 1000, 6},
      '{10, 100, -500, 0, 1000, 3}, '{100, 2000, 0, 0, 2000, 4},
      '{0, 100, 20000, -1000, 20000, 7}};
   int rv [7] = '{0, 100, 0, 0, 1000, 1000, 0};
   int ext [6] = '{250, 100, 0, 0, 1000, 5};
   logic [31:0] d;
   // Clock
   initial begin
      forever #12.5 clk = ~clk;
   end
   sapw_source sapw_source_i (.clk(clk), .enable_in(enable_in),
      .analog_sample_in(analog_sample_in), .period_ext_in(period_ext_in));
   sapw_top #(.TICK_CYCLES(TK)) sapw_top_i (.clk(clk),
      .reset_n(reset_n), .ce(ce), .enable_in(enable_in),
      .analog_sample_in(analog_sample_in), .period_ext_in(period_ext_in),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm_out),
      .running(running));
   task automatic results;
      if (mismatches == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s expected %0h seen %0h", n, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      @(negedge clk);
      d = reg_rdata;
   endtask
   function automatic int sat(int v, int l);
      return v > l ? l : (v < -l ? -l : v);
   endfunction
   // Expected high steps per period
   function automatic int hi(int r [6]);
      int s;
      s = r[0] * sat(r[1], 1000) / 100 + sat(r[2], 10000);
      if (s <= r[3] || r[4] <= r[3]) return 0;
      if (s >= r[4]) return r[5];
      return (r[5] * (s - r[3]) + r[4] - r[3] - 1) / (r[4] - r[3]);
   endfunction
   // Start, count two periods of high time, then stop
   task automatic run(input int r [6], input logic [15:0] pe);
      int h;
      int n;
      h = 0;
      n = 0;
      sapw_source_i.drive(1'h1, 16'(r[0]), pe);
      while (running !== 1'h1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      chk("running", running, 1'h1);
      if (running !== 1'h1) results();
      @(negedge clk);
      repeat (2 * r[5] * TK) begin
         h += pwm_out;
         @(negedge clk);
      end
      chk("high", h, 2 * hi(r) * TK);
      sapw_source_i.drive(1'h0, 16'(r[0]), pe);
      repeat (5) @(negedge clk);
      chk("stop", {running, pwm_out}, 2'h0);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      reset_n <= 1'h1;
      foreach (rows[i]) begin
         sapw_source_i.drive(1'h0, 16'(rows[i][0]), 16'h0004);
         for (int j = 1; j < 6; j++) begin
            wr(8'(4 * j), rows[i][j]);
         end
         rd(`SAPW_OFS_GAIN);
         chk("gain", d, sat(rows[i][1], 1000));
         run(rows[i], 16'h0004);
      end
      // Reset values after a second reset
      sapw_source_i.drive(1'h0, 16'hFFF9, 16'h0005);
      reset_n <= 1'h0;
      repeat (2) @(posedge clk);
      reset_n <= 1'h1;
      foreach (rv[j]) begin
         rd(8'(4 * j));
         chk("reset value", d, rv[j]);
      end
      wr(`SAPW_OFS_DEC, 32'h3);
      rd(`SAPW_OFS_DEC);
      chk("decimals", d, 32'h3);
      // A write is ignored while the clock enable is low
      @(posedge clk);
      ce <= 1'h0;
      wr(`SAPW_OFS_DEC, 32'h1);
      ce <= 1'h1;
      rd(`SAPW_OFS_DEC);
      chk("frozen decimals", d, 32'h3);
      rd(`SAPW_OFS_SCALED);
      chk("scaled", d, 32'hFFFFFFF9);
      wr(`SAPW_OFS_STATUS, 32'h3);
      rd(`SAPW_OFS_STATUS);
      chk("status", d, 32'h0);
      rd(8'h40);
      chk("unmapped", d, 32'h0);
      // Period fed from another block
      sapw_source_i.drive(1'h0, 16'(ext[0]), 16'h0005);
      wr(`SAPW_OFS_CTRL, 32'h1);
      rd(`SAPW_OFS_PERIOD);
      chk("ext period", d, 32'h5);
      run(ext, 16'h0005);
      results();
   end
endmodule // testbench
bind sapw_top sapw_monitor #(.TICK_CYCLES(TICK_CYCLES)) sapw_monitor_i (
   .clk(clk), .reset_n(reset_n), .enable_in(enable_in),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .pwm_out(pwm_out), .running(running));
